// [mfso_select.sv]
`timescale 1ns/1ps
module mfso_select
  import mfso_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic                clk,       // 10 MHz system clock
  input  wire logic                sys_rst,   // Synchronous reset, active high
  input  wire mfso_bus_req_t       bus_req,   // Register bus request
  output logic      [DW-1:0]       bus_rdata, // Read data, cycle after read strobe
  input  wire mfso_status_t        drv,       // Internal drive status
  output logic      [N_TERM-1:0]   term_out   // Terminal closed when high
);

  typedef struct packed {
    logic [N_TERM-1:0][7:0] code;
    logic [2:0]             wh_unit;
    logic [1:0]             minf_sel;
    logic [15:0]            ref_up;
    logic [15:0]            ref_lo;
    logic [15:0]            ref_lo2;
    logic [15:0]            min_freq;
    logic [15:0]            servo_dev;
    logic [15:0]            fb_lo_thr;
    logic [15:0]            fb_lo_dly;
    logic [15:0]            fb_hi_thr;
    logic [15:0]            fb_hi_dly;
    logic [15:0]            brk_rel;
    logic [15:0]            brk_eng;
    logic [7:0]             rst_lim;
    logic [15:0]            ol_thr;
    logic [15:0]            oh_thr;
    logic [N_TERM-1:0]      term;
    logic [DW-1:0]          rdata;
    logic                   restart_on;
    logic [7:0]             restart_cnt;
    logic [15:0]            fb_lo_cnt;
    logic [15:0]            fb_hi_cnt;
    logic                   fb_lo_flag;
    logic                   fb_hi_flag;
    logic                   brake;
    logic [15:0]            tick_cnt;
    logic [41:0]            energy;
    logic [3:0]             pend;
    logic                   pulse_on;
    logic [7:0]             pulse_ms;
    logic [15:0]            pulses;
  } mfso_state_t;

  mfso_state_t st_reg;
  mfso_state_t st_next;

  logic [63:0] cond;
  logic        tick;
  logic [19:0] ol_scaled;
  logic [19:0] ol_limit;
  logic [41:0] unit_amt;
  logic [41:0] energy_sum;

  // Energy per pulse in watt-milliseconds
  function automatic logic [41:0] wh_unit_size(input logic [2:0] sel);
    logic [41:0] amt;
    amt = WH_UNIT_BASE;
    case (sel)
      3'h1:    amt = 42'(WH_UNIT_BASE * WH_TEN);
      3'h2:    amt = 42'(WH_UNIT_BASE * WH_TEN * WH_TEN);
      3'h3:    amt = 42'(WH_UNIT_BASE * WH_TEN * WH_TEN * WH_TEN);
      3'h4:    amt = 42'(WH_UNIT_BASE * WH_TEN * WH_TEN * WH_TEN * WH_TEN);
      default: amt = WH_UNIT_BASE;
    endcase
    return amt;
  endfunction

  // Maps a setting code to a terminal level
  function automatic logic term_level(input logic [7:0] code, input logic [63:0] c);
    logic [7:0] base;
    logic       inv;
    logic       lvl;
    base = code;
    inv  = 1'b0;
    if (code >= INV_BASE && code <= INV_LAST) begin
      base = code - INV_BASE;
      inv  = 1'b1;
    end
    lvl = (base < 8'h40) ? c[base[5:0]] : 1'b0;
    return lvl ^ inv;
  endfunction

  assign tick      = (st_reg.tick_cnt == 16'(TICK_CYC - 1));
  assign ol_scaled = 20'(drv.ol_level) * 20'h0000A;
  assign ol_limit  = 20'(st_reg.ol_thr) * 20'h00009;
  assign unit_amt  = wh_unit_size(st_reg.wh_unit);

  always_comb begin
    energy_sum = st_reg.energy;
    if (tick && !drv.out_power[15]) begin
      energy_sum = st_reg.energy + 42'(drv.out_power);
    end
  end

  always_comb begin
    cond = '0;
    cond[F_REVERSE[5:0]] = drv.reverse;
    cond[F_MOTOR2[5:0]]  = drv.motor2_sel;
    cond[F_REGEN[5:0]]   = drv.regenerating;
    cond[F_RESTART[5:0]] = st_reg.restart_on;
    cond[F_OL_PRE[5:0]]  = ol_scaled > ol_limit;
    cond[F_OH_PRE[5:0]]  = drv.hs_temp > st_reg.oh_thr;
    cond[F_WEAK[5:0]]    = drv.weakening_det;
    cond[F_TRQ_LIM[5:0]] = drv.at_torque_limit && (drv.ctrl_mode != MFSO_VF);
    cond[F_SPD_LIM[5:0]] = (drv.freq_ref >= st_reg.ref_up)
                         || (drv.freq_ref <= st_reg.ref_lo)
                         || (drv.freq_ref <= st_reg.ref_lo2)
                         || ((st_reg.minf_sel != 2'h0)
                             && (drv.freq_ref < st_reg.min_freq));
    cond[F_SPD_TC[5:0]]  = drv.torque_ctrl && drv.at_speed_limit_tc;
    cond[F_SERVO[5:0]]   = drv.servo_on && (drv.servo_dev <= st_reg.servo_dev);
    cond[F_FREQ[5:0]]    = drv.outputting && !drv.baseblock && !drv.dc_braking;
    cond[F_ENABLE[5:0]]  = drv.enable_input;
    cond[F_WH[5:0]]      = st_reg.pulse_on;
    cond[F_LOCAL[5:0]]   = drv.local_mode;
    cond[F_SEARCH[5:0]]  = drv.speed_search;
    cond[F_FB_LOW[5:0]]  = st_reg.fb_lo_flag;
    cond[F_FB_HIGH[5:0]] = st_reg.fb_hi_flag;
    cond[F_FSTOP[5:0]]   = drv.fast_stop_di;
    cond[F_ROTOR[5:0]]   = drv.run_cmd && drv.rotor_det_done;
    cond[F_BRAKE[5:0]]   = st_reg.brake;
  end

  always_comb begin
    st_next = st_reg;
    // Register writes
    if (bus_req.wr) begin
      if (bus_req.addr < A_WH_UNIT) begin
        st_next.code[bus_req.addr[1:0]] = bus_req.wdata[7:0];
      end
      case (bus_req.addr)
        A_WH_UNIT:   st_next.wh_unit   = bus_req.wdata[2:0];
        A_MINF_SEL:  st_next.minf_sel  = bus_req.wdata[1:0];
        A_REF_UP:    st_next.ref_up    = bus_req.wdata;
        A_REF_LO:    st_next.ref_lo    = bus_req.wdata;
        A_REF_LO2:   st_next.ref_lo2   = bus_req.wdata;
        A_MIN_FREQ:  st_next.min_freq  = bus_req.wdata;
        A_SERVO_DEV: st_next.servo_dev = bus_req.wdata;
        A_FB_LO_THR: st_next.fb_lo_thr = bus_req.wdata;
        A_FB_LO_DLY: st_next.fb_lo_dly = bus_req.wdata;
        A_FB_HI_THR: st_next.fb_hi_thr = bus_req.wdata;
        A_FB_HI_DLY: st_next.fb_hi_dly = bus_req.wdata;
        A_BRK_REL:   st_next.brk_rel   = bus_req.wdata;
        A_BRK_ENG:   st_next.brk_eng   = bus_req.wdata;
        A_RST_LIM:   st_next.rst_lim   = bus_req.wdata[7:0];
        A_OL_THR:    st_next.ol_thr    = bus_req.wdata;
        A_OH_THR:    st_next.oh_thr    = bus_req.wdata;
        default:     st_next.rdata     = st_reg.rdata;
      endcase
    end
    // Read data stands for one cycle only
    st_next.rdata = '0;
    if (bus_req.rd) begin
      if (bus_req.addr < A_WH_UNIT) begin
        st_next.rdata = {8'h00, st_reg.code[bus_req.addr[1:0]]};
      end
      case (bus_req.addr)
        A_WH_UNIT:   st_next.rdata = {13'h0000, st_reg.wh_unit};
        A_MINF_SEL:  st_next.rdata = {14'h0000, st_reg.minf_sel};
        A_REF_UP:    st_next.rdata = st_reg.ref_up;
        A_REF_LO:    st_next.rdata = st_reg.ref_lo;
        A_REF_LO2:   st_next.rdata = st_reg.ref_lo2;
        A_MIN_FREQ:  st_next.rdata = st_reg.min_freq;
        A_SERVO_DEV: st_next.rdata = st_reg.servo_dev;
        A_FB_LO_THR: st_next.rdata = st_reg.fb_lo_thr;
        A_FB_LO_DLY: st_next.rdata = st_reg.fb_lo_dly;
        A_FB_HI_THR: st_next.rdata = st_reg.fb_hi_thr;
        A_FB_HI_DLY: st_next.rdata = st_reg.fb_hi_dly;
        A_BRK_REL:   st_next.rdata = st_reg.brk_rel;
        A_BRK_ENG:   st_next.rdata = st_reg.brk_eng;
        A_RST_LIM:   st_next.rdata = {8'h00, st_reg.rst_lim};
        A_OL_THR:    st_next.rdata = st_reg.ol_thr;
        A_OH_THR:    st_next.rdata = st_reg.oh_thr;
        A_STATUS:    st_next.rdata = {st_reg.restart_cnt, st_reg.pulse_on, st_reg.brake,
                                      st_reg.fb_hi_flag, st_reg.fb_lo_flag, st_reg.term};
        A_PULSES:    st_next.rdata = st_reg.pulses;
        default:     st_next.rdata = st_next.rdata;
      endcase
    end

    // Automatic restart tracking
    if (drv.restart_attempt) begin
      st_next.restart_on  = 1'b1;
      st_next.restart_cnt = st_reg.restart_cnt + 8'h01;
    end else if (drv.fault_cleared) begin
      st_next.restart_on  = 1'b0;
      st_next.restart_cnt = 8'h00;
    end else if (drv.fault_trip && st_reg.restart_cnt >= st_reg.rst_lim) begin
      st_next.restart_on  = 1'b0;
      st_next.restart_cnt = 8'h00;
    end

    // Millisecond time base
    st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;

    // Feedback low/high with delay in milliseconds
    if (drv.pid_fb >= st_reg.fb_lo_thr) begin
      st_next.fb_lo_cnt  = 16'h0000;
      st_next.fb_lo_flag = 1'b0;
    end else if (tick) begin
      if (st_reg.fb_lo_cnt >= st_reg.fb_lo_dly) begin
        st_next.fb_lo_flag = 1'b1;
      end else begin
        st_next.fb_lo_cnt = st_reg.fb_lo_cnt + 16'h0001;
      end
    end
    if (drv.pid_fb <= st_reg.fb_hi_thr) begin
      st_next.fb_hi_cnt  = 16'h0000;
      st_next.fb_hi_flag = 1'b0;
    end else if (tick) begin
      if (st_reg.fb_hi_cnt >= st_reg.fb_hi_dly) begin
        st_next.fb_hi_flag = 1'b1;
      end else begin
        st_next.fb_hi_cnt = st_reg.fb_hi_cnt + 16'h0001;
      end
    end

    // Brake hysteresis: close needs both, open needs both
    if (drv.run_cmd && drv.out_freq >= st_reg.brk_rel) begin
      st_next.brake = 1'b1;
    end else if (!drv.run_cmd && drv.out_freq <= st_reg.brk_eng) begin
      st_next.brake = 1'b0;
    end

    // Energy accumulation and pulse queue
    st_next.energy = energy_sum;
    if (energy_sum >= unit_amt) begin
      st_next.energy = energy_sum - unit_amt;
      if (st_reg.pend != PEND_MAX) begin
        st_next.pend = st_reg.pend + 4'h1;
      end
    end
    if (tick) begin
      if (st_reg.pulse_on) begin
        if (st_reg.pulse_ms == PULSE_MS - 8'h01) begin
          st_next.pulse_on = 1'b0;
        end else begin
          st_next.pulse_ms = st_reg.pulse_ms + 8'h01;
        end
      end else if (st_next.pend != 4'h0) begin
        st_next.pulse_on = 1'b1;
        st_next.pulse_ms = 8'h00;
        st_next.pend     = st_next.pend - 4'h1;
        st_next.pulses   = st_reg.pulses + 16'h0001;
      end
    end
    if (!drv.ctrl_power_ok) begin
      st_next.energy = '0;
      st_next.pend   = 4'h0;
    end

    for (int i = 0; i < N_TERM; i++) begin
      st_next.term[i] = term_level(st_reg.code[i], cond);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.ref_up  <= REF_UP_RST;
      st_reg.brk_rel <= BRK_REL_RST;
      st_reg.brk_eng <= BRK_ENG_RST;
      st_reg.ol_thr  <= OL_THR_RST;
      st_reg.oh_thr  <= OH_THR_RST;
      st_reg.rst_lim <= RST_LIM_RST[7:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign term_out  = st_reg.term;
  assign bus_rdata = st_reg.rdata;

endmodule

// [mfso_pkg.sv]
// Function
// - Code 22: closed while motor turns in reverse, open when forward.
// - Code 23: open with motor set one, closed with motor set two.
// - Code 24: closed while the motor is regenerating.
// - Code 25: closed during restart attempts; opens on clear or final trip.
// - Code 26: closed when overload level exceeds ninety percent of threshold.
// - Code 27: closed while heatsink temperature exceeds overheat threshold.
// - Code 29: closed when mechanical weakening is detected.
// - Code 31: closed at torque limit, in every control mode except V/f.
// - Code 32: closed at upper limit, lower limit, or below minimum frequency.
// - Code 33: closed when torque control reaches the speed limit.
// - Code 34: closed when zero-servo on and deviation within allowance.
// - Code 35: closed while outputting, open in stop, blocking, DC braking.
// - Code 36: mirrors the enable digital input.
// - Code 38: closed in local mode, open in remote mode.
// - Code 39: closed throughout speed search.
// - Codes 40/41: feedback below/above threshold longer than delay closes.
// - Code 44: closed during a fast stop from a digital input.
// - Code 46: closed after run given and rotor detection finished.
// - Code 49: brake closes on run and release; opens on stop and engage.
// - Codes 100 to 149 invert the function of code minus one hundred.
// - Code 37: 200 ms pulse per selected energy unit, 0.1 to 1000 kWh.
// - Energy never decreases on negative power; cleared on control power loss.
package mfso_pkg;
  localparam int          N_TERM       = 4;
  localparam int          AW           = 8;
  localparam int          DW           = 16;
  localparam int          CLK_HZ       = 10000000;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYCLES  = TICK_US * (CLK_HZ / 1000000);
  localparam logic [7:0]  PULSE_MS     = 8'hC8;
  localparam logic [7:0]  INV_BASE     = 8'h64;
  localparam logic [7:0]  INV_LAST     = 8'h95;
  localparam logic [41:0] WH_UNIT_BASE = 42'h000015752A00;
  localparam logic [41:0] WH_TEN       = 42'h00000000000A;
  localparam logic [3:0]  PEND_MAX     = 4'hF;
  // Register indices
  localparam logic [AW-1:0] A_CODE0     = 8'h00;
  localparam logic [AW-1:0] A_WH_UNIT   = 8'h04;
  localparam logic [AW-1:0] A_MINF_SEL  = 8'h05;
  localparam logic [AW-1:0] A_REF_UP    = 8'h06;
  localparam logic [AW-1:0] A_REF_LO    = 8'h07;
  localparam logic [AW-1:0] A_REF_LO2   = 8'h08;
  localparam logic [AW-1:0] A_MIN_FREQ  = 8'h09;
  localparam logic [AW-1:0] A_SERVO_DEV = 8'h0A;
  localparam logic [AW-1:0] A_FB_LO_THR = 8'h0B;
  localparam logic [AW-1:0] A_FB_LO_DLY = 8'h0C;
  localparam logic [AW-1:0] A_FB_HI_THR = 8'h0D;
  localparam logic [AW-1:0] A_FB_HI_DLY = 8'h0E;
  localparam logic [AW-1:0] A_BRK_REL   = 8'h0F;
  localparam logic [AW-1:0] A_BRK_ENG   = 8'h10;
  localparam logic [AW-1:0] A_RST_LIM   = 8'h11;
  localparam logic [AW-1:0] A_OL_THR    = 8'h12;
  localparam logic [AW-1:0] A_OH_THR    = 8'h13;
  localparam logic [AW-1:0] A_STATUS    = 8'h14;
  localparam logic [AW-1:0] A_PULSES    = 8'h15;
  // Function codes
  localparam logic [7:0] F_REVERSE = 8'h16;
  localparam logic [7:0] F_MOTOR2  = 8'h17;
  localparam logic [7:0] F_REGEN   = 8'h18;
  localparam logic [7:0] F_RESTART = 8'h19;
  localparam logic [7:0] F_OL_PRE  = 8'h1A;
  localparam logic [7:0] F_OH_PRE  = 8'h1B;
  localparam logic [7:0] F_WEAK    = 8'h1D;
  localparam logic [7:0] F_TRQ_LIM = 8'h1F;
  localparam logic [7:0] F_SPD_LIM = 8'h20;
  localparam logic [7:0] F_SPD_TC  = 8'h21;
  localparam logic [7:0] F_SERVO   = 8'h22;
  localparam logic [7:0] F_FREQ    = 8'h23;
  localparam logic [7:0] F_ENABLE  = 8'h24;
  localparam logic [7:0] F_WH      = 8'h25;
  localparam logic [7:0] F_LOCAL   = 8'h26;
  localparam logic [7:0] F_SEARCH  = 8'h27;
  localparam logic [7:0] F_FB_LOW  = 8'h28;
  localparam logic [7:0] F_FB_HIGH = 8'h29;
  localparam logic [7:0] F_FSTOP   = 8'h2C;
  localparam logic [7:0] F_ROTOR   = 8'h2E;
  localparam logic [7:0] F_BRAKE   = 8'h31;
  localparam logic [15:0] REF_UP_RST  = 16'h1770;
  localparam logic [15:0] BRK_REL_RST = 16'h0014;
  localparam logic [15:0] BRK_ENG_RST = 16'h000A;
  localparam logic [15:0] OL_THR_RST  = 16'h03E8;
  localparam logic [15:0] OH_THR_RST  = 16'h0064;
  localparam logic [15:0] RST_LIM_RST = 16'h0003;

  typedef enum logic [2:0] {
    MFSO_VF, MFSO_OPEN_LOOP_VECTOR_MODE, MFSO_CLOSED_LOOP_VECTOR_MODE,
    MFSO_ADVANCED_OPEN_LOOP_MAGNET_MODE, MFSO_CLOSED_LOOP_MAGNET_MODE
  } mfso_ctrl_mode_t;

  typedef struct packed {
    logic                reverse;
    logic                motor2_sel;
    logic                regenerating;
    logic                restart_attempt;
    logic                fault_cleared;
    logic                fault_trip;
    logic [15:0]         ol_level;
    logic [15:0]         hs_temp;
    logic                weakening_det;
    logic                at_torque_limit;
    mfso_ctrl_mode_t     ctrl_mode;
    logic [15:0]         freq_ref;
    logic                torque_ctrl;
    logic                at_speed_limit_tc;
    logic                servo_on;
    logic [15:0]         servo_dev;
    logic                outputting;
    logic                baseblock;
    logic                dc_braking;
    logic                enable_input;
    logic                local_mode;
    logic                speed_search;
    logic [15:0]         pid_fb;
    logic                fast_stop_di;
    logic                run_cmd;
    logic                rotor_det_done;
    logic [15:0]         out_freq;
    logic signed [15:0]  out_power;
    logic                ctrl_power_ok;
  } mfso_status_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } mfso_bus_req_t;
endpackage

// [mfso_meter.sv]
`timescale 1ns/1ps
module mfso_meter (
  input  wire logic        clk,       // System clock
  input  wire logic        sys_rst,   // Clears the tallies
  input  wire logic        pulse_in,  // Contact from the block, closed high
  output logic      [15:0] count,     // Pulses seen
  output logic      [31:0] len        // Length of the last pulse in cycles
);
  typedef struct packed {
    logic        prev;
    logic [31:0] run;
    logic [15:0] cnt;
    logic [31:0] len;
  } mfso_meter_t;
  mfso_meter_t state_reg;
  mfso_meter_t state_next;
  always_comb begin
    state_next      = state_reg;
    state_next.prev = pulse_in;
    state_next.run  = pulse_in ? state_reg.run + 32'h1 : 32'h0;
    if (pulse_in && !state_reg.prev) begin
      state_next.cnt = state_reg.cnt + 16'h1;
    end
    if (!pulse_in && state_reg.prev) begin
      state_next.len = state_reg.run;
    end
  end
  always_ff @(posedge clk) begin
    state_reg <= sys_rst ? '0 : state_next;
  end
  assign count = state_reg.cnt;
  assign len   = state_reg.len;
endmodule

// [mfso_asserts.sv]
`timescale 1ns/1ps
module mfso_asserts
  import mfso_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic              clk,       // System clock
  input wire logic              sys_rst,   // Synchronous reset
  input wire mfso_bus_req_t     bus_req,   // Register bus request
  input wire logic [DW-1:0]     bus_rdata, // Read data
  input wire mfso_status_t      drv,       // Drive status
  input wire logic [N_TERM-1:0] term_out   // Terminals
);
  localparam int PULSE_CYC = int'(PULSE_MS) * TICK_CYC;
  typedef struct packed {
    logic [N_TERM-1:0][7:0] code;
    logic [31:0]            hi;
  } mfso_chk_t;
  mfso_chk_t state_reg;
  mfso_chk_t state_next;
  // Shadow of the terminal codes and length of the high run on terminal 1
  always_comb begin
    state_next    = state_reg;
    state_next.hi = term_out[1] ? state_reg.hi + 32'h1 : 32'h0;
    if (bus_req.wr && bus_req.addr < 8'h04) begin
      state_next.code[bus_req.addr[1:0]] = bus_req.wdata[7:0];
    end
  end
  always_ff @(posedge clk) begin
    state_reg <= sys_rst ? '0 : state_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_attempt;
    state_reg.code[0] == F_RESTART && drv.restart_attempt;
  endsequence
  sequence s_restart_held;
    state_reg.code[0] == F_RESTART;
  endsequence
  AST_RESET_OPEN: assert property (disable iff (1'b0) sys_rst |=> term_out == 4'h0)
    else $error("terminals not open after reset");
  AST_REVERSE: assert property (state_reg.code[0] == F_REVERSE |=> term_out[0] == $past(drv.reverse))
    else $error("reverse indication wrong");
  AST_MOTOR2: assert property (state_reg.code[0] == F_MOTOR2 |=> term_out[0] == $past(drv.motor2_sel))
    else $error("motor set indication wrong");
  AST_REGEN: assert property (state_reg.code[0] == F_REGEN |=> term_out[0] == $past(drv.regenerating))
    else $error("regeneration indication wrong");
  AST_RESTART: assert property (s_attempt ##1 s_restart_held |=> term_out[0])
    else $error("restart indication not closed");
  AST_OVERHEAT: assert property (state_reg.code[0] == F_OH_PRE |=> term_out[0] == $past(drv.hs_temp > OH_THR_RST))
    else $error("overheat indication wrong");
  AST_BLOCKED: assert property ((state_reg.code[0] == F_FREQ && (drv.baseblock || drv.dc_braking)) |=> !term_out[0])
    else $error("frequency output closed while blocked");
  AST_ENABLE: assert property (state_reg.code[0] == F_ENABLE |=> term_out[0] == $past(drv.enable_input))
    else $error("enable mirror wrong");
  AST_LOCAL: assert property (state_reg.code[0] == F_LOCAL |=> term_out[0] == $past(drv.local_mode))
    else $error("local indication wrong");
  AST_INVERT: assert property (state_reg.code[0] == 8'h7A |=> term_out[0] != $past(drv.reverse))
    else $error("inverted reverse wrong");
  AST_RESERVED: assert property ((state_reg.code[0] inside {8'h12, 8'h14, 8'h1C, 8'h1E, 8'h2B, 8'h2F}
    || (state_reg.code[0] > 8'h31 && state_reg.code[0] < 8'h64)) |=> !term_out[0])
    else $error("reserved code closed the terminal");
  AST_PULSE_LEN: assert property ((state_reg.code[1] == F_WH && $fell(term_out[1])) |-> state_reg.hi == PULSE_CYC)
    else $error("energy pulse length wrong");
  AST_RD_IDLE: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside read");
endmodule

bind mfso_select mfso_asserts #(.TICK_CYC(TICK_CYC)) u_mfso_asserts (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .drv(drv), .term_out(term_out));

// [mfso_tb.sv]
`timescale 1ns/1ps
module testbench;
  import mfso_pkg::*;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  mfso_bus_req_t req = '0;
  mfso_status_t  st;
  logic [DW-1:0] rdata;
  logic [DW-1:0] d;
  logic [3:0]    term;
  logic [15:0]   mcnt;
  logic [31:0]   mlen;
  int            errors = 0;
  int            cmp_count = 0;
  // Row: code, then expected terminal in bit 7 and stimulus number below it
  logic [15:0]   rows [32] = '{16'h1681, 16'h1600, 16'h1782, 16'h1883, 16'h1A84, 16'h1A14,
    16'h1B85, 16'h1B15, 16'h1D86, 16'h1F87, 16'h1F08, 16'h2089, 16'h218A, 16'h228B, 16'h238C,
    16'h230D, 16'h248E, 16'h268F, 16'h2790, 16'h2C91, 16'h2E92, 16'h2E13, 16'h7A01, 16'h7A80,
    16'h870C, 16'h1C01, 16'h1E01, 16'h2B01, 16'h3201, 16'hC801, 16'h8080, 16'h1201};
  int            bf [5] = '{25, 26, 25, 27, 28};
  logic [4:0]    be = 5'b01110;
  always #50 clk = ~clk;
  mfso_select #(.TICK_CYC(2)) u_mfso_select (.clk(clk), .sys_rst(sys_rst), .bus_req(req),
    .bus_rdata(rdata), .drv(st), .term_out(term));
  mfso_meter u_mfso_meter (.clk(clk), .sys_rst(sys_rst), .pulse_in(term[1]), .count(mcnt),
    .len(mlen));
  function automatic mfso_status_t mk(input int f);
    mfso_status_t s;
    s = '0;
    s.ctrl_power_ok = 1'b1;
    s.freq_ref      = 16'h0100;
    s.pid_fb        = 16'h0200;
    case (f)
      1: s.reverse = 1'b1;
      2: s.motor2_sel = 1'b1;
      3: s.regenerating = 1'b1;
      4: s.ol_level = 16'h03B6;
      5: s.hs_temp = 16'h00C8;
      6: s.weakening_det = 1'b1;
      7: begin
        s.ctrl_mode       = MFSO_OPEN_LOOP_VECTOR_MODE;
        s.at_torque_limit = 1'b1;
      end
      8: s.at_torque_limit = 1'b1;
      9: s.freq_ref = 16'h1770;
      10: begin
        s.torque_ctrl       = 1'b1;
        s.at_speed_limit_tc = 1'b1;
      end
      11: s.servo_on = 1'b1;
      12: s.outputting = 1'b1;
      13: begin
        s.outputting = 1'b1;
        s.baseblock  = 1'b1;
      end
      14: s.enable_input = 1'b1;
      15: s.local_mode = 1'b1;
      16: s.speed_search = 1'b1;
      17: s.fast_stop_di = 1'b1;
      18: begin
        s.run_cmd        = 1'b1;
        s.rotor_det_done = 1'b1;
      end
      19: s.rotor_det_done = 1'b1;
      20: s.ol_level = 16'h0384;
      21: s.hs_temp = 16'h0064;
      22: s.restart_attempt = 1'b1;
      23: s.fault_cleared = 1'b1;
      24: s.fault_trip = 1'b1;
      25: begin
        s.run_cmd  = 1'b1;
        s.out_freq = 16'h0013;
      end
      26: begin
        s.run_cmd  = 1'b1;
        s.out_freq = 16'h0014;
      end
      27: s.out_freq = 16'h000B;
      28: s.out_freq = 16'h000A;
      29: s.pid_fb = 16'h0000;
      30: s.pid_fb = 16'h0400;
      31: s.out_power = 16'sh7D00;
      32: s.out_power = -16'sh7D00;
      33: s.ctrl_power_ok = 1'b0;
      default: ;
    endcase
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic put(input int f, input int n);
    @(posedge clk);
    st <= mk(f);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    st = mk(0);
    repeat (5) @(posedge clk);
    #1 chk(term, 4'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      put(rows[i][6:0], 0);
      wr(A_CODE0, {8'h00, rows[i][15:8]});
      put(rows[i][6:0], 3);
      chk(term[0], rows[i][7]);
    end
    $display("code table done");
    rd(A_REF_UP, d); chk(d, 16'h1770);
    rd(8'hFF, d); chk(d, 16'h0000);
    wr(A_PULSES, 16'h00FF); rd(A_PULSES, d); chk(d, 16'h0000);
    put(0, 1); chk(rdata, 16'h0000);
    wr(8'h03, 16'h0080); put(0, 3); chk(term, 4'h8);
    rd(A_STATUS, d); chk(d, 16'h0028);
    $display("register bus done");
    wr(A_CODE0, {8'h00, F_RESTART});
    put(22, 0); put(0, 3); chk(term[0], 1'b1);
    put(24, 0); put(0, 3); chk(term[0], 1'b1);
    put(23, 0); put(0, 3); chk(term[0], 1'b0);
    repeat (3) begin
      put(22, 0);
      put(0, 0);
    end
    put(24, 0); put(0, 3); chk(term[0], 1'b0);
    $display("restart done");
    wr(A_CODE0, {8'h00, F_BRAKE});
    foreach (bf[i]) begin
      put(bf[i], 3);
      chk(term[0], be[i]);
    end
    $display("brake done");
    wr(A_FB_LO_THR, 16'h0100); wr(A_FB_LO_DLY, 16'h0005); wr(A_CODE0, {8'h00, F_FB_LOW});
    put(29, 4); chk(term[0], 1'b0);
    put(29, 20); chk(term[0], 1'b1);
    put(0, 3); chk(term[0], 1'b0);
    wr(A_FB_HI_THR, 16'h0300); wr(A_FB_HI_DLY, 16'h0003); wr(A_CODE0, {8'h00, F_FB_HIGH});
    put(30, 4); chk(term[0], 1'b0);
    put(30, 16); chk(term[0], 1'b1);
    wr(A_CODE0, {8'h00, F_SPD_LIM}); wr(A_MIN_FREQ, 16'h0200);
    put(0, 3); chk(term[0], 1'b0);
    wr(A_MINF_SEL, 16'h0001); put(0, 3); chk(term[0], 1'b1);
    wr(A_MINF_SEL, 16'h0000); wr(A_REF_LO2, 16'h0100); put(0, 3); chk(term[0], 1'b1);
    $display("limits done");
    wr(8'h01, {8'h00, F_WH});
    put(31, 22000); chk(mcnt, 16'h0000);
    put(32, 400); put(31, 800); put(0, 600);
    chk(mcnt, 16'h0001);
    chk(mlen, 32'd400);
    put(31, 22000); chk(mcnt, 16'h0001);
    put(33, 5); put(31, 600); put(0, 600); chk(mcnt, 16'h0001);
    $display("energy done");
    wr(A_CODE0, 16'h007A); put(0, 3); chk(term[0], 1'b1);
    @(posedge clk);
    sys_rst <= 1'b1;
    put(0, 1); chk(term, 4'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    put(0, 1); chk(term, 4'h0);
    rd(A_CODE0, d); chk(d, 16'h0000);
    $display("reset done");
    complete_run();
  end
  initial begin
    repeat (70000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
